// >>> hdl/pms_regs.svh
// Register offsets, field positions and reset values of the power-mode sequencer.
// Assumes a 12-bit APB byte address; each register takes one aligned 32-bit word.
`ifndef PMS_REGS_SVH
`define PMS_REGS_SVH

`define PMS_ADDR_WIDTH 12
`define PMS_PLL_CONTROL_OFFSET 12'h000
`define PMS_REGULATOR_CONTROL_OFFSET 12'h004
`define PMS_STATUS_OFFSET 12'h008
`define PMS_WAKE_CONFIG_OFFSET 12'h00c

`define PMS_PLL_DISABLE_BIT 0
`define PMS_PLL_BYPASS_BIT 1
`define PMS_PLL_SLEEP_CMD_BIT 2
`define PMS_PLL_DEEP_SLEEP_CMD_BIT 3
`define PMS_PLL_MULT_LSB 8
`define PMS_PLL_MULT_MSB 13
`define PMS_PLL_MULT_RESET 6'h0a

`define PMS_REG_REGULATOR_FREQUENCY_FIELD_LSB 0
`define PMS_REG_REGULATOR_FREQUENCY_FIELD_MSB 1
`define PMS_REG_REGULATOR_FREQUENCY_FIELD_RESET 2'h3
`define PMS_REG_REGULATOR_FREQUENCY_FIELD_HIBERNATE 2'h0

`define PMS_WAKE_CAN_UNUSED_BIT 0
`define PMS_WAKE_MAC_UNUSED_BIT 1

`define PMS_STATUS_STATE_LSB 0
`define PMS_STATUS_STATE_MSB 2
`define PMS_STATUS_MULT_LSB 8
`define PMS_STATUS_MULT_MSB 13

`endif

// >>> hdl/pms_pkg.sv
// Types shared by the power-mode sequencer and its bench.
// Assumes nothing of its surroundings.
package pms_pkg;

  typedef enum logic [2:0] {
    pms_full_on = 3'b000,
    pms_active = 3'b001,
    pms_sleep = 3'b010,
    pms_deep_sleep = 3'b011,
    pms_hibernate = 3'b100
  } pms_state_type;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pms_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pms_apb_rsp_type;

  typedef struct packed {
    logic rtc;
    logic can;
    logic media_ring_mac;
    logic network_receive_activity_pin;
    logic general;
  } pms_wake_type;

  typedef struct packed {
    logic core_clock_enable;
    logic system_clock_enable;
    logic pll_enable;
    logic pll_bypass;
    logic core_regulator_on;
    logic pins_high_z;
    logic l1_dma_allow;
    logic async_access_block;
    logic [5:0] multiplier;
  } pms_clock_ctrl_type;

endpackage

// >>> hdl/pms_sync.sv
// Three-flop synchroniser for asynchronous wake pins, one chain per bit.
// Assumes the inputs are levels from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none

module pms_sync #(
  parameter int WIDTH = 5
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // The output moves only once the second and third stages agree
      always_ff @(posedge clk) begin
        if (reset) begin
          stage1[i] <= 1'b0;
          stage2[i] <= 1'b0;
          stage3[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          stage1[i] <= async_in[i];
          stage2[i] <= stage1[i];
          stage3[i] <= stage2[i];
          if (stage2[i] == stage3[i]) begin
            sync_out[i] <= stage3[i];
          end
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// >>> hdl/pms_power_mode_sequencer.sv
// Power-mode sequencer: state machine, clock and regulator controls, APB registers.
// Assumes a free-running reference clock, a synchronous reset and raw wake pins.
// Function
// (RULE_01) Power-up enters full-on, PLL on, unbypassed
// (RULE_02) Active bypasses PLL, clocks at reference
// (RULE_03) Multiplier change applies on entering full-on
// (RULE_04) Software re-enables PLL before full-on or sleep
// (RULE_05) Sleep gates core clock, PLL, system run
// (RULE_06) Sleep wake picks full-on or active by bypass
// (RULE_07) No level-one DMA during sleep
// (RULE_08) Level-one DMA stays allowed in active
// (RULE_09) Deep sleep gates both clocks, narrow exits
// (RULE_10) Deep sleep: clock wake to active, reset full-on
// (RULE_11) Deep sleep blocks asynchronous peripheral accesses
// (RULE_12) Frequency field zero enters hibernate, supply off
// (RULE_13) Hibernate puts pins in high impedance
// (RULE_14) Hibernate wakes on clock, CAN, reset, ring
// (RULE_15) General wake allowed when CAN or MAC unused
// (RULE_16) Media ring MAC wakes from sleep
// (RULE_17) Every hibernate wake starts boot sequence
// (RULE_18) Wakes ignored in full-on and active
// (RULE_19) Current state readable as encoded value
`timescale 1ns/1ps
`default_nettype none
`include "pms_regs.svh"

module pms_power_mode_sequencer (
  input wire logic clk,
  input wire logic reset,
  input wire pms_pkg::pms_apb_req_type apb_req,
  output pms_pkg::pms_apb_rsp_type apb_rsp,
  input wire pms_pkg::pms_wake_type wake_pins,
  output pms_pkg::pms_clock_ctrl_type clock_ctrl,
  output pms_pkg::pms_state_type state_out,
  output logic boot_request
);
  import pms_pkg::*;

  pms_state_type state;
  pms_state_type next_state;
  pms_clock_ctrl_type next_clock_ctrl;
  pms_wake_type wake;
  logic [4:0] wake_sync;

  logic pll_disable;
  logic bypass;
  logic [5:0] mult_pending;
  logic [5:0] mult_active;
  logic [1:0] regulator_frequency_field;
  logic can_unused;
  logic mac_unused;
  logic [31:0] read_data;
  logic read_error;

  pms_sync #(
    .WIDTH(5)
  ) u_wake_sync (
    .clk(clk),
    .reset(reset),
    .async_in(wake_pins),
    .sync_out(wake_sync)
  );

  assign wake = wake_sync;

  // Bus decode
  wire setup = apb_req.psel & ~apb_req.penable;
  wire write_access = apb_req.psel & apb_req.penable & apb_req.pwrite;
  wire sel_pll = apb_req.paddr == `PMS_PLL_CONTROL_OFFSET;
  wire sel_regulator = apb_req.paddr == `PMS_REGULATOR_CONTROL_OFFSET;
  wire sel_status = apb_req.paddr == `PMS_STATUS_OFFSET;
  wire sel_wake = apb_req.paddr == `PMS_WAKE_CONFIG_OFFSET;
  wire mapped = sel_pll | sel_regulator | sel_status | sel_wake;
  wire powered = state != pms_hibernate;

  wire pll_write = write_access & sel_pll & powered;
  wire regulator_write = write_access & sel_regulator & powered;
  wire wake_write = write_access & sel_wake & powered;
  wire [31:0] wdata = apb_req.pwdata;
  wire run_state = (state == pms_full_on) | (state == pms_active);

  wire sleep_cmd = pll_write & wdata[`PMS_PLL_SLEEP_CMD_BIT] & run_state;
  wire deep_cmd = pll_write & wdata[`PMS_PLL_DEEP_SLEEP_CMD_BIT] & run_state;
  wire bypass_wr = wdata[`PMS_PLL_BYPASS_BIT];
  wire [1:0] regulator_frequency_field_wr = wdata[`PMS_REG_REGULATOR_FREQUENCY_FIELD_MSB:`PMS_REG_REGULATOR_FREQUENCY_FIELD_LSB];
  wire hibernate_cmd = regulator_write & (regulator_frequency_field_wr == `PMS_REG_REGULATOR_FREQUENCY_FIELD_HIBERNATE); // RULE_12

  // Wake qualification per state
  wire sleep_wake = wake.rtc | wake.can | wake.general | wake.network_receive_activity_pin
                    | wake.media_ring_mac; // RULE_16
  wire general_hib_wake = wake.general & (can_unused | mac_unused); // RULE_15
  wire hib_wake = wake.rtc | wake.can | wake.network_receive_activity_pin
                  | general_hib_wake; // RULE_14
  wire deep_wake = wake.rtc; // RULE_09
  wire leave_hibernate = (state == pms_hibernate) & hib_wake;
  wire rtc_from_deep = (state == pms_deep_sleep) & deep_wake;

  // Next register values
  wire next_pll_disable = pll_write ? wdata[`PMS_PLL_DISABLE_BIT] : pll_disable;
  wire next_bypass = rtc_from_deep ? 1'b1 : (pll_write ? bypass_wr : bypass);
  wire [5:0] next_mult_pending = pll_write ? wdata[`PMS_PLL_MULT_MSB:`PMS_PLL_MULT_LSB]
                                            : mult_pending;
  wire enter_full_on = (next_state == pms_full_on) & (state != pms_full_on);
  wire [5:0] next_mult_active = enter_full_on ? mult_pending : mult_active; // RULE_03
  wire [1:0] next_regulator_frequency_field = leave_hibernate ? `PMS_REG_REGULATOR_FREQUENCY_FIELD_RESET
                         : (regulator_write ? regulator_frequency_field_wr : regulator_frequency_field);
  wire next_can_unused = wake_write ? wdata[`PMS_WAKE_CAN_UNUSED_BIT] : can_unused;
  wire next_mac_unused = wake_write ? wdata[`PMS_WAKE_MAC_UNUSED_BIT] : mac_unused;
  wire next_boot_request = leave_hibernate; // RULE_17

  // Read data is captured in the setup cycle so the access phase needs no wait
  wire [31:0] pll_read = {18'h00000, mult_pending, 6'h00, bypass, pll_disable};
  wire [31:0] regulator_read = {30'h00000000, regulator_frequency_field};
  wire [31:0] status_read = {18'h00000, mult_active, 5'h00, state}; // RULE_19
  wire [31:0] wake_read = {30'h00000000, mac_unused, can_unused};
  wire [31:0] read_mux = sel_pll ? pll_read
                       : sel_regulator ? regulator_read
                       : sel_status ? status_read
                       : sel_wake ? wake_read
                       : 32'h00000000;
  wire [31:0] next_read_data = setup ? read_mux : read_data;
  wire next_read_error = setup ? ~mapped : read_error;

  // State transitions; hibernate entry outranks every other request
  always_comb begin
    next_state = state;
    if (hibernate_cmd) begin
      next_state = pms_hibernate;
    end else begin
      unique case (state)
        pms_full_on: begin
          // Wake pins are not looked at here
          if (deep_cmd) begin
            next_state = pms_deep_sleep;
          end else if (sleep_cmd) begin
            next_state = pms_sleep; // RULE_04
          end else if (pll_write & bypass_wr) begin
            next_state = pms_active;
          end // RULE_18
        end
        pms_active: begin
          if (deep_cmd) begin
            next_state = pms_deep_sleep;
          end else if (sleep_cmd) begin
            next_state = pms_sleep; // RULE_04
          end else if (pll_write & ~bypass_wr) begin
            next_state = pms_full_on; // RULE_04
          end // RULE_18
        end
        pms_sleep: begin
          if (sleep_wake) begin
            next_state = bypass ? pms_active : pms_full_on; // RULE_06
          end
        end
        pms_deep_sleep: begin
          if (deep_wake) begin
            next_state = pms_active; // RULE_10
          end
        end
        pms_hibernate: begin
          if (hib_wake) begin
            next_state = pms_full_on; // RULE_14
          end
        end
      endcase
    end
  end

  // Clock, supply and access controls follow the state being entered
  always_comb begin
    next_clock_ctrl = '0;
    next_clock_ctrl.multiplier = next_mult_active;
    unique case (next_state)
      pms_full_on: begin
        next_clock_ctrl.core_clock_enable = 1'b1; // RULE_01
        next_clock_ctrl.system_clock_enable = 1'b1;
        next_clock_ctrl.pll_enable = 1'b1;
        next_clock_ctrl.pll_bypass = 1'b0;
        next_clock_ctrl.core_regulator_on = 1'b1;
        next_clock_ctrl.l1_dma_allow = 1'b1;
      end
      pms_active: begin
        next_clock_ctrl.core_clock_enable = 1'b1; // RULE_02
        next_clock_ctrl.system_clock_enable = 1'b1;
        next_clock_ctrl.pll_enable = ~next_pll_disable;
        next_clock_ctrl.pll_bypass = 1'b1;
        next_clock_ctrl.core_regulator_on = 1'b1;
        next_clock_ctrl.l1_dma_allow = 1'b1; // RULE_08
      end
      pms_sleep: begin
        next_clock_ctrl.core_clock_enable = 1'b0; // RULE_05
        next_clock_ctrl.system_clock_enable = 1'b1;
        next_clock_ctrl.pll_enable = 1'b1;
        next_clock_ctrl.pll_bypass = next_bypass;
        next_clock_ctrl.core_regulator_on = 1'b1;
        next_clock_ctrl.l1_dma_allow = 1'b0; // RULE_07
      end
      pms_deep_sleep: begin
        next_clock_ctrl.core_clock_enable = 1'b0; // RULE_09
        next_clock_ctrl.system_clock_enable = 1'b0;
        next_clock_ctrl.core_regulator_on = 1'b1;
        next_clock_ctrl.async_access_block = 1'b1; // RULE_11
      end
      pms_hibernate: begin
        next_clock_ctrl.core_regulator_on = 1'b0; // RULE_12
        next_clock_ctrl.pins_high_z = 1'b1; // RULE_13
        next_clock_ctrl.async_access_block = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= pms_full_on; // RULE_10
      pll_disable <= 1'b0;
      bypass <= 1'b0;
      mult_pending <= `PMS_PLL_MULT_RESET;
      mult_active <= `PMS_PLL_MULT_RESET;
      regulator_frequency_field <= `PMS_REG_REGULATOR_FREQUENCY_FIELD_RESET;
      can_unused <= 1'b0;
      mac_unused <= 1'b0;
      read_data <= 32'h00000000;
      read_error <= 1'b0;
      boot_request <= 1'b1;
    end else begin
      state <= next_state;
      pll_disable <= next_pll_disable;
      bypass <= next_bypass;
      mult_pending <= next_mult_pending;
      mult_active <= next_mult_active;
      regulator_frequency_field <= next_regulator_frequency_field;
      can_unused <= next_can_unused;
      mac_unused <= next_mac_unused;
      read_data <= next_read_data;
      read_error <= next_read_error;
      boot_request <= next_boot_request;
    end
  end

  // Reset value puts the sequencer in full-on with the default multiplier
  always_ff @(posedge clk) begin
    if (reset) begin
      clock_ctrl <= {1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, `PMS_PLL_MULT_RESET}; // RULE_01
    end else begin
      clock_ctrl <= next_clock_ctrl;
    end
  end

  assign state_out = state; // RULE_19
  assign apb_rsp.prdata = read_data;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = read_error & apb_req.psel & apb_req.penable;

endmodule

`default_nettype wire

// >>> dv/pms_monitor.sv
// Checker on the ports of the power-mode sequencer.
// Assumes it is bound to the sequencer top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module pms_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire pms_pkg::pms_apb_req_type apb_req,
  input wire pms_pkg::pms_apb_rsp_type apb_rsp,
  input wire pms_pkg::pms_wake_type wake_pins,
  input wire pms_pkg::pms_clock_ctrl_type clock_ctrl,
  input wire pms_pkg::pms_state_type state_out,
  input wire logic boot_request
);
  import pms_pkg::*;
  wire pms_state_type st = state_out;
  wire logic [7:0] fl = clock_ctrl[13:6];
  wire logic wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
  default clocking mcb @(posedge clk); endclocking
  default disable iff (reset);
  a_full_on_flags: assert property (st == pms_full_on |-> fl == 8'hea)
    else $error("full-on controls wrong");
  a_active_flags: assert property (st == pms_active |-> fl ==? 8'b11?11010)
    else $error("active controls wrong");
  a_sleep_flags: assert property (st == pms_sleep |-> fl ==? 8'b011?1000)
    else $error("sleep controls wrong");
  a_deep_flags: assert property (st == pms_deep_sleep |-> fl == 8'h09)
    else $error("deep sleep controls wrong");
  a_hibernate_flags: assert property (st == pms_hibernate |-> fl == 8'h05)
    else $error("hibernate controls wrong");
  a_mult_on_entry: assert property (!$past(reset) && $changed(clock_ctrl.multiplier)
    |-> st == pms_full_on && $past(st) != pms_full_on) else $error("multiplier changed late");
  a_sleep_exit: assert property (!$past(reset) && $past(st) == pms_sleep &&
    !(st inside {pms_sleep, pms_hibernate})
    |-> st == ($past(clock_ctrl.pll_bypass) ? pms_active : pms_full_on))
    else $error("sleep exit state wrong");
  a_deep_exit: assert property (st == pms_deep_sleep ##1 st != pms_deep_sleep
    |-> st inside {pms_active, pms_hibernate}) else $error("deep sleep exit wrong");
  a_wake_ignored: assert property (st inside {pms_full_on, pms_active} && !wr
    |=> st == $past(st)) else $error("state left without a write");
  a_hib_boot: assert property (st == pms_hibernate ##1 st != pms_hibernate
    |-> boot_request ##1 !boot_request) else $error("boot request not one pulse on hibernate exit");
endmodule
bind pms_power_mode_sequencer pms_monitor pms_monitor_inst (.clk(clk), .reset(reset),
  .apb_req(apb_req), .apb_rsp(apb_rsp), .wake_pins(wake_pins), .clock_ctrl(clock_ctrl),
  .state_out(state_out), .boot_request(boot_request));
`default_nettype wire

// >>> dv/pms_wake_model.sv
// Wake sources outside the sequencer, driving its wake pins.
// Assumes fire is a one-cycle request mask from the bench.
`timescale 1ns/1ps
`default_nettype none
module pms_wake_model (
  input wire logic clk,
  input wire logic [4:0] fire,
  input wire logic slow,
  output pms_pkg::pms_wake_type wake_pins
);
  import pms_pkg::*;
  logic [4:0] mask = 5'h0;
  logic [3:0] cnt = 4'h0;
  // A slow source raises its pin five cycles late
  always @(posedge clk) begin
    if (fire != 5'h0) begin
      mask <= fire;
      cnt <= slow ? 4'hd : 4'h8;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end
  end
  // Released pins fall back to their inactive low level
  assign wake_pins = (cnt != 4'h0 && cnt <= 4'h8) ? mask : 5'h0;
endmodule
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for the power-mode sequencer with a wake-source model.
// Assumes the checker is bound to the sequencer by its own file.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pms_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic slow = 1'b0;
  logic [4:0] fire = 5'h0;
  pms_apb_req_type req = '0;
  pms_apb_rsp_type rsp;
  pms_wake_type wake;
  pms_clock_ctrl_type ctrl;
  pms_state_type state;
  logic boot;
  logic e;
  logic byp = 1'b0;
  logic pd = 1'b0;
  logic [31:0] r;
  logic [5:0] mp;
  logic [5:0] mu = 6'h0a;
  logic [4:0] srcs [3] = '{5'h08, 5'h02, 5'h01};
  int seed = 32'hac5bd527;
  int miscompares = 0;
  int comparisons = 0;
  initial forever #25 clk = ~clk;
  pms_wake_model pms_wake_model_inst (.clk(clk), .fire(fire), .slow(slow), .wake_pins(wake));
  pms_power_mode_sequencer pms_power_mode_sequencer_inst (.clk(clk), .reset(reset),
    .apb_req(req), .apb_rsp(rsp), .wake_pins(wake), .clock_ctrl(ctrl), .state_out(state),
    .boot_request(boot));
  task give_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic pms_clock_ctrl_type ctrl_of(input pms_state_type s);
    case (s)
      pms_full_on: return {8'hea, mu};
      pms_active: return {2'b11, ~pd, 5'h1a, mu};
      pms_sleep: return {3'b011, byp, 4'h8, mu};
      pms_deep_sleep: return {8'h09, mu};
      default: return {8'h05, mu};
    endcase
  endfunction
  task expect_state(input pms_state_type s);
    for (int n = 0; n < 20 && state !== s; n++) begin
      @(posedge clk);
      #1;
    end
    chk("state and controls", {15'h0, s, ctrl_of(s)}, {15'h0, state, ctrl});
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    r = rsp.prdata;
    e = rsp.pslverr;
    req <= '0;
    #1;
  endtask
  task wr_pll(input logic [3:0] cmd);
    apb(1'b1, 12'h000, {18'h0, mp, 4'h0, cmd});
  endtask
  task pulse(input logic [4:0] m, input logic hold);
    @(posedge clk);
    fire <= m;
    slow <= 1'($random(seed));
    @(posedge clk);
    fire <= 5'h0;
    if (hold) repeat (20) @(posedge clk);
    #1;
  endtask
  task hib_wake(input logic [4:0] m);
    pulse(m, 1'b0);
    expect_state(pms_full_on);
    chk("boot request", 32'h1, {31'h0, boot});
    // Let the wake pins drop before the next hibernate entry
    repeat (20) @(posedge clk);
  endtask
  initial begin
    mp = 6'h0a;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    expect_state(pms_full_on);
    apb(1'b0, 12'h004, 32'h0);
    chk("frequency field", 32'h3, r);
    apb(1'b0, 12'h010, 32'h0);
    chk("unmapped read", 32'h1, {r[30:0], e});
    wr_pll(4'h2);
    expect_state(pms_active);
    pulse(5'h10, 1'b1);
    expect_state(pms_active);
    // New multiplier written in active must stay pending
    mp = 6'($random(seed)) | 6'h20;
    wr_pll(4'h3);
    pd = 1'b1;
    expect_state(pms_active);
    wr_pll(4'h2);
    pd = 1'b0;
    expect_state(pms_active);
    wr_pll(4'h0);
    mu = mp;
    expect_state(pms_full_on);
    apb(1'b0, 12'h008, 32'h0);
    chk("status", {18'h0, mp, 8'h0}, r);
    for (int i = 0; i < 5; i++) begin
      byp = i[0];
      wr_pll({2'b01, byp, 1'b0});
      expect_state(pms_sleep);
      pulse(5'h10 >> i, 1'b1);
      expect_state(byp ? pms_active : pms_full_on);
    end
    wr_pll(4'h8);
    expect_state(pms_deep_sleep);
    pulse(5'h08, 1'b1);
    expect_state(pms_deep_sleep);
    pulse(5'h10, 1'b1);
    expect_state(pms_active);
    wr_pll(4'h8);
    expect_state(pms_deep_sleep);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    mu = 6'h0a;
    byp = 1'b0;
    expect_state(pms_full_on);
    apb(1'b1, 12'h00c, 32'h0);
    apb(1'b1, 12'h004, 32'h0);
    expect_state(pms_hibernate);
    pulse(5'h05, 1'b1);
    expect_state(pms_hibernate);
    hib_wake(5'h10);
    apb(1'b1, 12'h00c, 32'h1);
    foreach (srcs[j]) begin
      apb(1'b1, 12'h004, 32'h0);
      expect_state(pms_hibernate);
      hib_wake(srcs[j]);
    end
    apb(1'b1, 12'h00c, 32'h2);
    apb(1'b0, 12'h00c, 32'h0);
    chk("wake config", 32'h2, r);
    apb(1'b1, 12'h004, 32'h0);
    expect_state(pms_hibernate);
    hib_wake(5'h01);
    apb(1'b1, 12'h004, 32'h0);
    expect_state(pms_hibernate);
    reset <= 1'b1;
    @(posedge clk);
    #1;
    chk("boot on reset", 32'h1, {31'h0, boot});
    reset <= 1'b0;
    expect_state(pms_full_on);
    give_verdict;
  end
  initial begin
    repeat (6000) @(posedge clk);
    miscompares++;
    give_verdict;
  end
endmodule
`default_nettype wire
